/* File: dv/ctoc_actuator_model.sv */
// Purpose: Chuck cylinder with clamp and release end switches.
// Assumes: Valve outputs come from the block under test.
// Notes: stall freezes the cylinder so no end switch is reached.
`timescale 1ns/100ps
`default_nettype none
module ctoc_actuator_model
  import ctoc_pkg::*;
#(
  parameter int TRAVEL = 5
)
(
  // Clock.
  input wire logic clk,
  // Valves and control.
  input wire ctoc_out_t act,
  input wire logic stall,
  // End switches.
  output logic clampInPos,
  output logic releaseInPos
);
  int pos = 0;
  int dir = 0;
  always @(posedge clk)
  begin
    if (act.chuckClampOut)
      dir <= 1;
    else if (act.chuckReleaseOut)
      dir <= -1;
    if (!stall && dir != 0 && pos * dir < TRAVEL)
      pos <= pos + dir;
  end
  assign clampInPos = (pos >= TRAVEL);
  assign releaseInPos = (pos <= -TRAVEL);
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the chuck and tailstock control.
// Assumes: One millisecond is shortened to ten clock cycles.
// Notes: Foot switches are tested after the register checks and before the commands, while the toggle is fresh.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import ctoc_pkg::*;
;
  localparam int MSC = 10;
  typedef struct packed
  {
    logic [7:0] set;
    ctoc_cmd_t c;
    ctoc_out_t a;
  } ctoc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] regAddr = '0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  ctoc_cmd_t cmd = '0;
  logic clampInPos;
  logic releaseInPos;
  logic chuckFoot = 1'b0;
  logic tailFoot = 1'b0;
  logic stall = 1'b0;
  ctoc_out_t act;
  logic innerClampMode;
  logic timeoutAlarm;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [15:0] rstVal [4] = '{16'(SETTINGS_RST), CHK_PULSE_RST, TS_PULSE_RST,
    TIMEOUT_RST};
  ctoc_row_t rows [10] = '{
    '{8'h00, 4'b1000, 4'b1010},
    '{8'h00, 4'b0100, 4'b0110},
    '{8'h00, 4'b0010, 4'b0110},
    '{8'h00, 4'b0001, 4'b0101},
    '{8'h40, 4'b1000, 4'b1001},
    '{8'h80, 4'b1000, 4'b0001},
    '{8'h90, 4'b0010, 4'b0001},
    '{8'h00, 4'b0100, 4'b0101},
    '{8'h00, 4'b1100, 4'b1001},
    '{8'h00, 4'b0011, 4'b1010}
  };

  always #5 clk = ~clk;

  chuck_tailstock_ctrl #(.MS_CYC(MSC)) dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cmd(cmd),
    .clampInPosPin(clampInPos), .releaseInPosPin(releaseInPos),
    .chuckFootPin(chuckFoot), .tailFootPin(tailFoot), .act(act),
    .innerClampMode(innerClampMode), .timeoutAlarm(timeoutAlarm));

  ctoc_actuator_model #(.TRAVEL(5)) model (
    .clk(clk), .act(act), .stall(stall), .clampInPos(clampInPos),
    .releaseInPos(releaseInPos));

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [15:0] exp, string what);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    check(what, exp, regRdata);
    @(posedge clk);
    #1;
    check("rdata idle", 16'h0000, regRdata);
  endtask

  task automatic issue(ctoc_cmd_t c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
  endtask

  task automatic press(logic ch, logic tl, logic [3:0] exp);
    @(posedge clk);
    chuckFoot <= ch;
    tailFoot <= tl;
    repeat (8) @(posedge clk);
    chuckFoot <= 1'b0;
    tailFoot <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("foot act", 16'(exp), 16'(act));
  endtask

  task automatic pulse(int idx, int exp, ctoc_cmd_t c, string what);
    int n;
    logic [3:0] av;
    n = 0;
    issue(c);
    repeat (exp + 30)
    begin
      @(posedge clk);
      #1;
      av = act;
      if (av[idx])
        n++;
    end
    check(what, 16'(exp), 16'(n));
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("reset act", 16'h0000, 16'(act));
    foreach (rstVal[i])
      rd(4'(i), rstVal[i], "reset reg");
    wr(4'h7, 16'h00ff);
    rd(ADDR_SETTINGS, 16'h0000, "unmapped write");
    rd(4'h6, 16'h0000, "unmapped read");
    press(1'b1, 1'b1, 4'b1010);
    press(1'b1, 1'b0, 4'b0110);
    wr(ADDR_SETTINGS, 16'h0003);
    press(1'b1, 1'b1, 4'b0110);
    foreach (rows[i])
    begin
      wr(ADDR_SETTINGS, {8'h00, rows[i].set});
      issue(rows[i].c);
      repeat (3) @(posedge clk);
      #1;
      check("act", 16'(rows[i].a), 16'(act));
      check("inner", 16'(rows[i].set[6]), 16'(innerClampMode));
    end
    wr(ADDR_CHK_PULSE, 16'h0002);
    rd(ADDR_CHK_PULSE, 16'h0002, "chuck pulse reg");
    wr(ADDR_TS_PULSE, 16'h0000);
    wr(ADDR_SETTINGS, 16'h000c);
    pulse(2, 2 * MSC, 4'b0100, "chuck pulse");
    pulse(0, MSC, 4'b0001, "tail pulse");
    check("pulse end", 16'h0000, 16'(act));
    wr(ADDR_TIMEOUT, 16'h0003);
    wr(ADDR_SETTINGS, 16'h0020);
    stall <= 1'b1;
    issue(4'b1000);
    repeat (3 * MSC - 1) @(posedge clk);
    #1;
    check("alarm early", 16'h0000, 16'(timeoutAlarm));
    @(posedge clk);
    #1;
    check("alarm late", 16'h0001, 16'(timeoutAlarm));
    rd(ADDR_STATUS, 16'h0128, "status");
    wr(ADDR_CLEAR, 16'h0001);
    @(posedge clk);
    #1;
    check("alarm clear", 16'h0000, 16'(timeoutAlarm));
    wr(ADDR_SETTINGS, 16'h0000);
    // A stalled clamp would time out if checking were still on.
    issue(4'b1000);
    repeat (50) @(posedge clk);
    #1;
    check("unchecked", 16'h0000, 16'(timeoutAlarm));
    wr(ADDR_SETTINGS, 16'h0020);
    stall <= 1'b0;
    issue(4'b1000);
    repeat (50) @(posedge clk);
    #1;
    check("confirmed", 16'h0000, 16'(timeoutAlarm));
    issue(4'b0100);
    repeat (50) @(posedge clk);
    #1;
    check("release confirmed", 16'h0000, 16'(timeoutAlarm));
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    check("mid reset act", 16'h0000, 16'(act));
    rd(ADDR_SETTINGS, 16'h0000, "mid reset reg");
    conclude();
  end
endmodule
`default_nettype wire

/* File: include/ctoc_pkg.sv */
// Purpose: Shared constants and types for the chuck and tailstock control.
// Assumes: 100 MHz system clock.
// Notes: Register map and settings bit positions live here.
package ctoc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int AW = 4;
  localparam logic [3:0] ADDR_SETTINGS = 4'h0;
  localparam logic [3:0] ADDR_CHK_PULSE = 4'h1;
  localparam logic [3:0] ADDR_TS_PULSE = 4'h2;
  localparam logic [3:0] ADDR_TIMEOUT = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CLEAR = 4'h5;
  localparam int B_CHK_OFF = 7;
  localparam int B_INNER = 6;
  localparam int B_RESP = 5;
  localparam int B_TS_OFF = 4;
  localparam int B_CHK_PULSE = 3;
  localparam int B_TS_PULSE = 2;
  localparam int B_CHK_FOOT_OFF = 1;
  localparam int B_TS_FOOT_OFF = 0;
  localparam logic [7:0] SETTINGS_RST = 8'h00;
  localparam logic [15:0] CHK_PULSE_RST = 16'h0064;
  localparam logic [15:0] TS_PULSE_RST = 16'h0064;
  localparam logic [15:0] TIMEOUT_RST = 16'h03e8;
  typedef enum logic [1:0] {
    CTOC_IDLE = 2'b00,
    CTOC_DRIVE = 2'b01,
    CTOC_HOLD = 2'b11
  } ctoc_state_t;
  typedef struct packed {
    logic clampCmd;
    logic releaseCmd;
    logic advanceCmd;
    logic retractCmd;
  } ctoc_cmd_t;
  typedef struct packed {
    logic chuckClampOut;
    logic chuckReleaseOut;
    logic tailAdvanceOut;
    logic tailRetractOut;
  } ctoc_out_t;
endpackage

/* File: rtl/chuck_tailstock_ctrl.sv */
// What this block does
// - Chuck disabled: refuse clamp/release, outputs low.
// - Clamp mode bit picks outer or inner.
// - Response check uses in-position inputs, else ignored.
// - Tailstock disabled: refuse advance and retract.
// - Chuck level form holds output steady.
// - Chuck pulse form lasts chuck pulse time.
// - Tailstock level form holds output steady.
// - Tailstock pulse form lasts tailstock pulse time.
// - Chuck foot switch accepted unless bit set.
// - Tailstock foot switch accepted unless bit set.
// - Missing confirmation within timeout raises alarm.
// Purpose: Chuck and tailstock output control with register port.
// Assumes: Foot switches and in-position inputs are asynchronous pins.
// Notes: Foot switch press toggles its function between the two ends.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module chuck_tailstock_ctrl
  import ctoc_pkg::*;
#(
  parameter int MS_CYC = CYC_PER_MS
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [AW-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Commands from the controller, one-cycle pulses.
  input wire ctoc_cmd_t cmd,
  // Field pins.
  input wire logic clampInPosPin,
  input wire logic releaseInPosPin,
  input wire logic chuckFootPin,
  input wire logic tailFootPin,
  // Actuator outputs and alarm.
  output ctoc_out_t act,
  output logic innerClampMode,
  output logic timeoutAlarm
);
  logic [7:0] settings_q, settings_d;
  logic [15:0] chkPulse_q, chkPulse_d;
  logic [15:0] tsPulse_q, tsPulse_d;
  logic [15:0] timeout_q, timeout_d;
  logic [15:0] rdata_q, rdata_d;
  logic [3:0] syn1_q, syn2_q, prev_q;
  logic chuckFootRise, tailFootRise;
  logic chuckSide_q, chuckSide_d, tailSide_q, tailSide_d;
  logic clampGo, releaseGo, advanceGo, retractGo;
  logic waitClamp_q, waitClamp_d, waitRel_q, waitRel_d;
  logic [16:0] cyc_q, cyc_d;
  logic [15:0] ms_q, ms_d;
  logic alarm_q, alarm_d;
  logic chkOff, tsOff, respOn;

  assign chkOff = settings_q[B_CHK_OFF];
  assign tsOff = settings_q[B_TS_OFF];
  assign respOn = settings_q[B_RESP];

  // Two-stage synchronisers for all pins.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      syn1_q <= '0;
      syn2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      syn1_q <= {tailFootPin, chuckFootPin, releaseInPosPin, clampInPosPin};
      syn2_q <= syn1_q;
      prev_q <= syn2_q;
    end
  end

  assign chuckFootRise = syn2_q[2] && !prev_q[2] &&
    !settings_q[B_CHK_FOOT_OFF];
  assign tailFootRise = syn2_q[3] && !prev_q[3] &&
    !settings_q[B_TS_FOOT_OFF];

  assign clampGo = !chkOff &&
    (cmd.clampCmd || (chuckFootRise && !chuckSide_q));
  assign releaseGo = !chkOff && !clampGo &&
    (cmd.releaseCmd || (chuckFootRise && chuckSide_q));
  assign advanceGo = !tsOff &&
    (cmd.advanceCmd || (tailFootRise && !tailSide_q));
  assign retractGo = !tsOff && !advanceGo &&
    (cmd.retractCmd || (tailFootRise && tailSide_q));

  always_comb
  begin
    chuckSide_d = chuckSide_q;
    tailSide_d = tailSide_q;
    if (clampGo)
      chuckSide_d = 1'b1;
    else if (releaseGo)
      chuckSide_d = 1'b0;
    if (advanceGo)
      tailSide_d = 1'b1;
    else if (retractGo)
      tailSide_d = 1'b0;
  end

  // Register writes and reads.
  always_comb
  begin
    settings_d = settings_q;
    chkPulse_d = chkPulse_q;
    tsPulse_d = tsPulse_q;
    timeout_d = timeout_q;
    rdata_d = '0;
    if (regWr)
    begin
      unique case (regAddr)
        ADDR_SETTINGS: settings_d = regWdata[7:0];
        ADDR_CHK_PULSE: chkPulse_d = regWdata;
        ADDR_TS_PULSE: tsPulse_d = regWdata;
        ADDR_TIMEOUT: timeout_d = regWdata;
        default: ;
      endcase
    end
    if (regRd)
    begin
      unique case (regAddr)
        ADDR_SETTINGS: rdata_d = {8'h00, settings_q};
        ADDR_CHK_PULSE: rdata_d = chkPulse_q;
        ADDR_TS_PULSE: rdata_d = tsPulse_q;
        ADDR_TIMEOUT: rdata_d = timeout_q;
        ADDR_STATUS: rdata_d = {7'h00, alarm_q, waitRel_q, waitClamp_q,
          syn2_q[1:0], act};
        default: rdata_d = '0;
      endcase
    end
  end

  always_comb
  begin
    waitClamp_d = waitClamp_q;
    waitRel_d = waitRel_q;
    cyc_d = cyc_q;
    ms_d = ms_q;
    alarm_d = alarm_q;
    if (regWr && regAddr == ADDR_CLEAR && regWdata[0])
      alarm_d = 1'b0;
    // Confirmations only counted when checking is enabled.
    if (!respOn)
    begin
      waitClamp_d = 1'b0;
      waitRel_d = 1'b0;
    end
    else if (clampGo || releaseGo)
    begin
      waitClamp_d = clampGo;
      waitRel_d = releaseGo;
      cyc_d = '0;
      ms_d = '0;
    end
    else if ((waitClamp_q && syn2_q[0]) || (waitRel_q && syn2_q[1]))
    begin
      waitClamp_d = 1'b0;
      waitRel_d = 1'b0;
    end
    else if (waitClamp_q || waitRel_q)
    begin
      if (cyc_q == 17'(MS_CYC - 1))
      begin
        cyc_d = '0;
        ms_d = ms_q + 16'h0001;
        if (ms_q + 16'h0001 >= timeout_q)
        begin
          alarm_d = 1'b1;
          waitClamp_d = 1'b0;
          waitRel_d = 1'b0;
        end
      end
      else
        cyc_d = cyc_q + 17'h00001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      settings_q <= SETTINGS_RST;
      chkPulse_q <= CHK_PULSE_RST;
      tsPulse_q <= TS_PULSE_RST;
      timeout_q <= TIMEOUT_RST;
      rdata_q <= '0;
      chuckSide_q <= 1'b0;
      tailSide_q <= 1'b0;
      waitClamp_q <= 1'b0;
      waitRel_q <= 1'b0;
      cyc_q <= '0;
      ms_q <= '0;
      alarm_q <= 1'b0;
    end
    else
    begin
      settings_q <= settings_d;
      chkPulse_q <= chkPulse_d;
      tsPulse_q <= tsPulse_d;
      timeout_q <= timeout_d;
      rdata_q <= rdata_d;
      chuckSide_q <= chuckSide_d;
      tailSide_q <= tailSide_d;
      waitClamp_q <= waitClamp_d;
      waitRel_q <= waitRel_d;
      cyc_q <= cyc_d;
      ms_q <= ms_d;
      alarm_q <= alarm_d;
    end
  end

  assign regRdata = rdata_q;
  assign timeoutAlarm = alarm_q;
  // Clamp mode presented to the hydraulics.
  assign innerClampMode = settings_q[B_INNER];

  logic chkA, chkB, tailA, tailB;
  ctoc_pulse_timer #(.MS_CYC(MS_CYC)) uChuck (
    .clk(clk),
    .rst(rst),
    .cmdA(clampGo),
    .cmdB(releaseGo),
    .pulseMode(settings_q[B_CHK_PULSE]),
    .pulseMs(chkPulse_q),
    .outA(chkA),
    .outB(chkB)
  );
  // Chuck outputs forced low while the chuck is disabled; tailstock outputs are not.
  assign act = {chkA && !chkOff, chkB && !chkOff, tailA, tailB};

  ctoc_pulse_timer #(.MS_CYC(MS_CYC)) uTail (
    .clk(clk),
    .rst(rst),
    .cmdA(advanceGo),
    .cmdB(retractGo),
    .pulseMode(settings_q[B_TS_PULSE]),
    .pulseMs(tsPulse_q),
    .outA(tailA),
    .outB(tailB)
  );

  chk_chuck_off: assert property (@(posedge clk) disable iff (rst)
    chkOff |-> !act.chuckClampOut && !act.chuckReleaseOut)
    else $error("Chuck output while disabled.");
  chk_tail_refused: assert property (@(posedge clk) disable iff (rst)
    tsOff && $past(tsOff) && !act.tailAdvanceOut |=>
    !act.tailAdvanceOut)
    else $error("Tailstock advanced while disabled.");
  chk_pair_excl: assert property (@(posedge clk) disable iff (rst)
    !(act.chuckClampOut && act.chuckReleaseOut) &&
    !(act.tailAdvanceOut && act.tailRetractOut))
    else $error("Opposing outputs together.");
  // A clamp taken with no new chuck command right after it.
  sequence s_clamp_taken;
    clampGo ##1 !clampGo && !releaseGo;
  endsequence
  chk_clamp_rise: assert property (@(posedge clk) disable iff (rst)
    s_clamp_taken |=> act.chuckClampOut || chkOff)
    else $error("Clamp output did not rise.");
  chk_level_hold: assert property (@(posedge clk) disable iff (rst)
    act.tailAdvanceOut && !settings_q[B_TS_PULSE] && !advanceGo &&
    !retractGo && !$changed(settings_q) |=> act.tailAdvanceOut)
    else $error("Level tailstock output dropped.");
  chk_check_off: assert property (@(posedge clk) disable iff (rst)
    !respOn |=> !waitClamp_q && !waitRel_q)
    else $error("Waiting with checking off.");
  chk_foot_ignore: assert property (@(posedge clk) disable iff (rst)
    settings_q[B_CHK_FOOT_OFF] && !cmd.clampCmd |-> !clampGo)
    else $error("Chuck foot switch not ignored.");
  chk_tfoot_ignore: assert property (@(posedge clk) disable iff (rst)
    settings_q[B_TS_FOOT_OFF] && !cmd.advanceCmd |-> !advanceGo)
    else $error("Tailstock foot switch not ignored.");
  chk_alarm_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(alarm_q) |-> $past(waitClamp_q || waitRel_q))
    else $error("Alarm without a pending check.");
  chk_mode_out: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == ADDR_SETTINGS |=>
    innerClampMode == $past(regWdata[B_INNER]))
    else $error("Clamp mode mismatch.");
  chk_alarm_hold: assert property (@(posedge clk) disable iff (rst)
    alarm_q && !(regWr && regAddr == ADDR_CLEAR) |=> alarm_q)
    else $error("Alarm dropped without a clear.");
  chk_confirm_clear: assert property (@(posedge clk) disable iff (rst)
    respOn && waitClamp_q && syn2_q[0] && !clampGo |=> !waitClamp_q)
    else $error("Clamp confirmation not taken.");
endmodule
`default_nettype wire

/* File: rtl/ctoc_pulse_timer.sv */
// Purpose: One output pair driven as level or as a timed pulse.
// Assumes: Commands are one-cycle pulses on the system clock.
// Notes: A new command drops the opposing output before its own.
`timescale 1ns/100ps
`default_nettype none
module ctoc_pulse_timer
  import ctoc_pkg::*;
#(
  parameter int MS_CYC = CYC_PER_MS
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Commands and setup.
  input wire logic cmdA,
  input wire logic cmdB,
  input wire logic pulseMode,
  input wire logic [15:0] pulseMs,
  // Outputs.
  output logic outA,
  output logic outB
);
  ctoc_state_t state_q, state_d;
  logic selB_q, selB_d;
  logic [16:0] cyc_q, cyc_d;
  logic [15:0] ms_q, ms_d;
  logic cmdAny;

  assign cmdAny = cmdA | cmdB;

  always_comb
  begin
    state_d = state_q;
    selB_d = selB_q;
    cyc_d = cyc_q;
    ms_d = ms_q;
    if (cmdAny)
    begin
      // Opposing output drops one cycle first.
      state_d = CTOC_DRIVE;
      selB_d = cmdB;
      cyc_d = '0;
      ms_d = '0;
    end
    else
    begin
      unique case (state_q)
        CTOC_IDLE: ;
        CTOC_DRIVE: state_d = CTOC_HOLD;
        CTOC_HOLD:
        begin
          if (pulseMode)
          begin
            if (cyc_q == 17'(MS_CYC - 1))
            begin
              cyc_d = '0;
              ms_d = ms_q + 16'h0001;
              if (ms_q + 16'h0001 >= pulseMs)
                state_d = CTOC_IDLE;
            end
            else
              cyc_d = cyc_q + 17'h00001;
          end
        end
        default: state_d = CTOC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= CTOC_IDLE;
      selB_q <= 1'b0;
      cyc_q <= '0;
      ms_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      selB_q <= selB_d;
      cyc_q <= cyc_d;
      ms_q <= ms_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      outA <= 1'b0;
      outB <= 1'b0;
    end
    else
    begin
      outA <= (state_d == CTOC_HOLD) && !selB_d;
      outB <= (state_d == CTOC_HOLD) && selB_d;
    end
  end

  chk_never_both: assert property (@(posedge clk) disable iff (rst)
    !(outA && outB)) else $error("Both outputs of a pair high.");
endmodule
`default_nettype wire
